// ---- core/prbw_writer.sv ----
`timescale 1ns/1ns
// Function
// - Buffer spans write pointer to limit minus one
// - Pointers translated as owner stage 1 addresses
// - Service set keeps profiling off, pointer held
// - Uncorrected fault refaults on next record write
// - Non-secure kernel owner selection
// - Hypervisor owner selection
// - Secure kernel owner selection
// - Non-secure kernel regime with optional stage 2
// - Kernel owner disables hypervisor and host user
// - Hypervisor regime, host regime under both bits
// - Buffer disable on state, width, enable, service
// - Memory type from translation entry, coherent
// - Invalidate sync waits for in-flight records
// - Record writes never break exclusive pairs
// - Register access undefined or trapped
// - Service holds pointer and discards records
// - Full event near limit, never past it
module prbw_writer
    import prbw_pkg::*;
#(
    parameter bit HAS_HYP     = 1'b1,
    parameter bit HAS_MONITOR = 1'b1,
    parameter int MAX_REC_LOG2 = 6
) (
    input  wire logic                     clk_i,            // Core clock
    input  wire logic                     reset_n_i,        // Async reset
    input  wire prbw_pkg::prbw_ctrl_t     ctrl_i,           // Owner/enable controls
    input  wire logic [1:0]               cur_el_i,         // Current level
    input  wire logic                     core_secure_i,    // Core secure state
    input  wire logic                     cur_a32_i,        // Core in 32-bit state
    input  wire logic                     owner_a32_i,      // Owner in 32-bit state
    input  wire logic [15:0]              address_space_id_k_i,         // Kernel regime ADDRESS_SPACE_ID
    input  wire logic [15:0]              address_space_id_h_i,         // Host regime ADDRESS_SPACE_ID
    input  wire logic [15:0]              virtual_machine_id_i,           // Current VIRTUAL_MACHINE_ID
    input  wire logic                     tbi_i,            // Owner top byte ignore
    input  wire logic [63:12]             limit_i,          // Limit pointer field
    input  wire logic                     ptr_we_i,         // Pointer write strobe
    input  wire logic [63:0]              ptr_wdata_i,      // Pointer write data
    input  wire logic                     stat_we_i,        // Status write strobe
    input  wire prbw_pkg::prbw_stat_t     stat_wdata_i,     // Status write data
    output logic [63:0]                   ptr_o,            // Write pointer
    output prbw_pkg::prbw_stat_t          stat_o,           // Status
    input  wire logic                     rec_valid_i,      // Record beat valid
    input  wire logic [63:0]              rec_data_i,       // Record beat data
    input  wire logic                     rec_first_i,      // First beat of record
    input  wire logic                     rec_last_i,       // Last beat of record
    output logic                          rec_ready_o,      // Beat taken
    output prbw_pkg::prbw_mem_req_t       mem_o,            // Memory write request
    output logic                          mem_valid_o,      // Request valid
    input  wire logic                     mem_ready_i,      // Request taken
    input  wire logic                     mem_done_i,       // Write completed
    input  wire prbw_pkg::prbw_mem_resp_t mem_resp_i,       // Completion result
    input  wire logic                     tlbi_sync_i,      // Invalidate sync pending
    output logic                          tlbi_sync_done_o, // Sync may complete
    output logic                          buffer_enable_o,  // Buffer enabled
    output logic                          prof_allowed_o,   // Profiling allowed here
    output logic                          owner_secure_o,   // Owner secure
    output logic [1:0]                    owner_el_o,       // Owner level
    output prbw_pkg::prbw_access_t        access_o          // Register access check
);
    import prbw_pkg::*;

    // ****************************************
    // Types and state
    // ****************************************
    typedef enum logic [2:0] {
        PRBW_ST_IDLE = 3'b001,
        PRBW_ST_REQ  = 3'b010,
        PRBW_ST_WAIT = 3'b100
    } prbw_state_t;

    localparam logic [63:0] MAX_REC = 64'h1 << MAX_REC_LOG2;
    localparam logic [63:0] BEAT    = 64'(BEAT_BYTES);

    prbw_state_t   state_ff;
    prbw_state_t   nxt_state;
    logic [63:0]   ptr_ff;
    logic [63:0]   done_ptr_ff;
    prbw_stat_t    stat_ff;
    prbw_mem_req_t req_ff;
    logic          last_ff;

    // Address compare ignores the top byte when tagged
    function automatic logic [63:0] cmp_addr(input logic [63:0] a, input logic top_byte_ignore);
        cmp_addr = top_byte_ignore ? {8'h00, a[TOP_LSB-1:0]} : a;
    endfunction

    // ****************************************
    // Owner, regime and enable decode
    // ****************************************
    logic         own_secure;
    logic         own_hyp;
    logic         in_host;
    logic         buf_en;
    logic [1:0]   own_el;
    prbw_regime_t regime;

    always_comb begin
        // Secure kernel vs non-secure ownership
        own_secure = HAS_MONITOR ? !ctrl_i.secure_owner_select[1] : core_secure_i;
        // Hypervisor owns only in non-secure with select 00
        own_hyp    = !own_secure && HAS_HYP && (ctrl_i.hyp_owner_select == SEL_OWN_HYP);
        own_el     = own_hyp ? EL_HYP : EL_KERNEL;
        in_host    = !core_secure_i && HAS_HYP && ctrl_i.host_trap_general;
        if (own_secure) begin
            regime = PRBW_RG_S_K10;
        end else if (own_hyp) begin
            // Host regime only when both host bits set
            regime = (ctrl_i.host_extension_bit && ctrl_i.host_trap_general)
                     ? PRBW_RG_HOST : PRBW_RG_HYP;
        end else begin
            regime = PRBW_RG_NS_K10;
        end
        // Security state, width, enable bit and service
        buf_en = !owner_a32_i
                 && ((HAS_MONITOR ? ctrl_i.nonsecure_state_bit : !core_secure_i) == !own_secure)
                 && ctrl_i.buffer_enable_bit
                 && !stat_ff.service_flag;
    end

    assign buffer_enable_o = buf_en;
    assign owner_secure_o  = own_secure;
    assign owner_el_o      = own_el;
    // Kernel owner: off at hypervisor level and host user
    assign prof_allowed_o  = buf_en && !cur_a32_i && (cur_el_i <= own_el)
                             && (own_secure == core_secure_i)
                             && !(in_host && !own_hyp);

    // ****************************************
    // Register access check
    // ****************************************
    always_comb begin
        if (cur_el_i == EL_USER || cur_a32_i) begin
            access_o = PRBW_ACC_UNDEF;
        end else if (HAS_HYP && !core_secure_i && cur_el_i == EL_KERNEL
                     && !ctrl_i.hyp_owner_select[0]) begin
            access_o = PRBW_ACC_TRAP_HV;
        end else if (HAS_MONITOR && cur_el_i != EL_MONITOR
                     && ctrl_i.secure_owner_select != {ctrl_i.nonsecure_state_bit, 1'b1}) begin
            access_o = PRBW_ACC_TRAP_MN;
        end else begin
            access_o = PRBW_ACC_OK;
        end
    end

    // ****************************************
    // Beat acceptance and bounds
    // ****************************************
    logic [63:0] lim_addr;
    logic [63:0] beat_end;
    logic        beat_fits;
    logic        take_beat;
    logic        done_ok;
    logic        done_err;
    logic        full_evt;
    logic        over_evt;

    assign lim_addr  = {limit_i, 12'h000};
    // Beat must end at or below the limit
    assign beat_end  = ptr_ff + BEAT;
    assign beat_fits = cmp_addr(beat_end, tbi_i) <= cmp_addr(lim_addr, tbi_i);
    // Hold new beats while an invalidate sync drains
    assign rec_ready_o = (state_ff == PRBW_ST_IDLE) && !tlbi_sync_i
                         && (buf_en || stat_ff.service_flag);
    // While in service, records are swallowed
    assign take_beat = rec_valid_i && rec_ready_o && buf_en && beat_fits;
    assign over_evt  = rec_valid_i && rec_ready_o && buf_en && !beat_fits;
    assign done_ok   = (state_ff == PRBW_ST_WAIT) && mem_done_i
                       && !mem_resp_i.fault && !mem_resp_i.abort;
    assign done_err  = (state_ff == PRBW_ST_WAIT) && mem_done_i
                       && (mem_resp_i.fault || mem_resp_i.abort);
    // Room left below limit after a whole record
    assign full_evt  = done_ok && last_ff
                       && (cmp_addr(beat_end, tbi_i) + MAX_REC > cmp_addr(lim_addr, tbi_i));

    // ****************************************
    // Write state machine
    // ****************************************
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            PRBW_ST_IDLE: begin
                if (take_beat) begin
                    nxt_state = PRBW_ST_REQ;
                end
            end
            PRBW_ST_REQ: begin
                if (mem_ready_i) begin
                    nxt_state = PRBW_ST_WAIT;
                end
            end
            PRBW_ST_WAIT: begin
                if (mem_done_i) begin
                    nxt_state = PRBW_ST_IDLE;
                end
            end
            default: nxt_state = PRBW_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_ff <= PRBW_ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ****************************************
    // Memory request
    // ****************************************
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            req_ff  <= '0;
            last_ff <= 1'b0;
        end else if (take_beat) begin
            last_ff                 <= rec_last_i;
            // Owner stage 1 address, translated like any other
            req_ff.va               <= ptr_ff;
            req_ff.data             <= rec_data_i;
            req_ff.regime           <= regime;
            req_ff.address_space_id             <= (regime == PRBW_RG_HOST) ? address_space_id_h_i : address_space_id_k_i;
            req_ff.virtual_machine_id             <= virtual_machine_id_i;
            req_ff.stage2           <= (regime == PRBW_RG_NS_K10) && HAS_HYP
                                       && ctrl_i.stage2_enable;
            req_ff.top_byte_ignore              <= tbi_i;
            req_ff.attr_from_table  <= 1'b1;
            req_ff.as_profiled_core <= 1'b1;
            req_ff.keep_exclusive   <= 1'b1;
        end
    end

    assign mem_o       = req_ff;
    assign mem_valid_o = (state_ff == PRBW_ST_REQ);
    // Nothing in flight means every earlier translation is used up
    assign tlbi_sync_done_o = tlbi_sync_i && (state_ff == PRBW_ST_IDLE);

    // ****************************************
    // Write pointer
    // ****************************************
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ptr_ff <= '0;
        end else if (done_ok) begin
            ptr_ff <= beat_end;
        end else if (over_evt) begin
            // Never write past the limit; rewind to last whole record
            ptr_ff <= done_ptr_ff;
        end else if (ptr_we_i && !done_err) begin
            // Any value accepted, checked only when records flow
            ptr_ff <= ptr_wdata_i;
        end
    end

    // Pointer after the last complete record
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            done_ptr_ff <= '0;
        end else if (done_ok && last_ff) begin
            done_ptr_ff <= beat_end;
        end else if (ptr_we_i) begin
            done_ptr_ff <= ptr_wdata_i;
        end else if (take_beat && rec_first_i) begin
            done_ptr_ff <= ptr_ff;
        end
    end

    assign ptr_o = ptr_ff;

    // ****************************************
    // Status
    // ****************************************
    // Hardware events win over a same-cycle software write
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            stat_ff <= '0;
        end else if (done_err) begin
            // Fault left in place refaults on the next record
            stat_ff.service_flag <= 1'b1;
            stat_ff.data_loss_flag <= stat_ff.data_loss_flag || (ptr_ff != done_ptr_ff);
            if (mem_resp_i.abort && !mem_resp_i.fault) begin
                stat_ff.external_abort_flag <= 1'b1;
            end else begin
                stat_ff.ec       <= mem_resp_i.stage2 ? EC_S2_ABORT : EC_S1_ABORT;
                stat_ff.syndrome <= mem_resp_i.fsc;
            end
        end else if ((full_evt || over_evt) && !stat_ff.service_flag) begin
            stat_ff.service_flag <= 1'b1;
            stat_ff.ec           <= EC_OTHER;
            stat_ff.syndrome     <= BSC_FULL;
            stat_ff.data_loss_flag <= stat_ff.data_loss_flag || over_evt;
        end else if (stat_we_i) begin
            stat_ff <= stat_wdata_i;
        end
    end

    assign stat_o = stat_ff;

endmodule

// ---- core/prbw_pkg.sv ----
package prbw_pkg;

    // ****************************************
    // Widths and bit positions
    // ****************************************
    localparam int VA_W          = 64;
    localparam int LIM_LSB       = 12;
    localparam int BEAT_BYTES    = 8;
    localparam int TOP_LSB       = 56;
    localparam int ADDRESS_SPACE_ID_W        = 16;
    localparam int VIRTUAL_MACHINE_ID_W        = 16;

    // ****************************************
    // Encodings
    // ****************************************
    localparam logic [5:0] EC_OTHER     = 6'h00;
    localparam logic [5:0] EC_S1_ABORT  = 6'h24;
    localparam logic [5:0] EC_S2_ABORT  = 6'h25;
    localparam logic [5:0] BSC_FULL     = 6'h01;
    localparam logic [1:0] SEL_OWN_HYP  = 2'h0;
    localparam logic [1:0] EL_USER      = 2'h0;
    localparam logic [1:0] EL_KERNEL    = 2'h1;
    localparam logic [1:0] EL_HYP       = 2'h2;
    localparam logic [1:0] EL_MONITOR   = 2'h3;

    typedef enum logic [1:0] {
        PRBW_RG_NS_K10 = 2'h0,
        PRBW_RG_HYP    = 2'h1,
        PRBW_RG_HOST   = 2'h2,
        PRBW_RG_S_K10  = 2'h3
    } prbw_regime_t;

    typedef enum logic [2:0] {
        PRBW_ACC_OK      = 3'h0,
        PRBW_ACC_UNDEF   = 3'h1,
        PRBW_ACC_TRAP_HV = 3'h2,
        PRBW_ACC_TRAP_MN = 3'h3
    } prbw_access_t;

    typedef struct packed {
        logic [1:0] secure_owner_select;
        logic [1:0] hyp_owner_select;
        logic       nonsecure_state_bit;
        logic       host_trap_general;
        logic       host_extension_bit;
        logic       stage2_enable;
        logic       buffer_enable_bit;
    } prbw_ctrl_t;

    typedef struct packed {
        logic       service_flag;
        logic       data_loss_flag;
        logic       external_abort_flag;
        logic [5:0] ec;
        logic [5:0] syndrome;
    } prbw_stat_t;

    typedef struct packed {
        logic [VA_W-1:0]   va;
        logic [63:0]       data;
        prbw_regime_t      regime;
        logic [ADDRESS_SPACE_ID_W-1:0] address_space_id;
        logic [VIRTUAL_MACHINE_ID_W-1:0] virtual_machine_id;
        logic              stage2;
        logic              top_byte_ignore;
        logic              attr_from_table;
        logic              as_profiled_core;
        logic              keep_exclusive;
    } prbw_mem_req_t;

    typedef struct packed {
        logic       fault;
        logic       abort;
        logic       stage2;
        logic [5:0] fsc;
    } prbw_mem_resp_t;

endpackage

// ---- test/prbw_writer_chk.sv ----
`timescale 1ns/1ns
// ****************************************
// Port checks of the buffer writer
// ****************************************
module prbw_writer_chk
    import prbw_pkg::*;
#(
    parameter bit HAS_HYP = 1'b1
) (
    input wire logic                    clk_i,            // Clock
    input wire logic                    reset_n_i,        // Reset
    input wire prbw_pkg::prbw_ctrl_t    ctrl_i,           // Controls
    input wire logic [1:0]              cur_el_i,         // Level
    input wire logic                    owner_a32_i,      // Owner 32-bit
    input wire logic [63:12]            limit_i,          // Limit
    input wire logic                    ptr_we_i,         // Pointer write
    input wire logic [63:0]             ptr_o,            // Pointer
    input wire prbw_pkg::prbw_stat_t    stat_o,           // Status
    input wire logic                    rec_ready_o,      // Beat ready
    input wire prbw_pkg::prbw_mem_req_t mem_o,            // Request
    input wire logic                    mem_valid_o,      // Request valid
    input wire logic                    tlbi_sync_i,      // Sync pending
    input wire logic                    tlbi_sync_done_o, // Sync done
    input wire logic                    buffer_enable_o,  // Enabled
    input wire logic                    prof_allowed_o,   // Allowed
    input wire logic                    owner_secure_o,   // Owner secure
    input wire logic [1:0]              owner_el_o        // Owner level
);
    logic         ns_kern;
    prbw_regime_t exp_rg;

    assign ns_kern = !owner_secure_o && owner_el_o == EL_KERNEL;
    assign exp_rg  = owner_secure_o ? PRBW_RG_S_K10 : ns_kern ? PRBW_RG_NS_K10 :
        (ctrl_i.host_extension_bit && ctrl_i.host_trap_general) ? PRBW_RG_HOST : PRBW_RG_HYP;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    AST_BUF_EN:
        assert property (buffer_enable_o == (ctrl_i.nonsecure_state_bit != owner_secure_o &&
            !owner_a32_i && ctrl_i.buffer_enable_bit && !stat_o.service_flag))
        else $error("buffer enable decode wrong");
    AST_PROF_OFF:
        assert property (prof_allowed_o |-> buffer_enable_o && !(ns_kern && HAS_HYP &&
            (cur_el_i == EL_HYP || (cur_el_i == EL_USER && ctrl_i.host_trap_general))))
        else $error("profiling allowed where it must be off");
    AST_SVC_HOLD:
        assert property (stat_o.service_flag && $past(stat_o.service_flag) && !$past(ptr_we_i)
            |-> $stable(ptr_o)) else $error("pointer moved in service");
    AST_PTR_STEP:
        assert property (!stat_o.service_flag && !$past(ptr_we_i) && !$stable(ptr_o)
            |-> ptr_o == $past(ptr_o) + 64'h8) else $error("pointer step not one beat");
    AST_LIMIT:
        assert property (mem_valid_o |-> mem_o.va + 64'h8 <= {limit_i, 12'h000})
        else $error("write past limit");
    AST_REGIME:
        assert property (mem_valid_o |-> mem_o.regime == exp_rg && mem_o.stage2 ==
            (ns_kern && HAS_HYP && ctrl_i.stage2_enable)) else $error("regime wrong");
    AST_FLAGS:
        assert property (mem_valid_o |-> mem_o.attr_from_table && mem_o.as_profiled_core &&
            mem_o.keep_exclusive) else $error("request flags wrong");
    AST_TLBI:
        assert property (tlbi_sync_i |-> !rec_ready_o && !(tlbi_sync_done_o && mem_valid_o))
        else $error("sync overlaps a write");
endmodule

bind prbw_writer prbw_writer_chk #(.HAS_HYP(HAS_HYP)) i_prbw_writer_chk (
    .clk_i, .reset_n_i, .ctrl_i, .cur_el_i, .owner_a32_i, .limit_i, .ptr_we_i, .ptr_o,
    .stat_o, .rec_ready_o, .mem_o, .mem_valid_o, .tlbi_sync_i, .tlbi_sync_done_o,
    .buffer_enable_o, .prof_allowed_o, .owner_secure_o, .owner_el_o
);

// ---- test/prbw_mem_model.sv ----
`timescale 1ns/1ns
// ****************************************
// Memory side, one write at a time
// ****************************************
module prbw_mem_model
    import prbw_pkg::*;
(
    input  wire logic                     clk_i,       // Clock
    input  wire logic                     reset_n_i,   // Reset
    input  wire logic                     mem_valid_i, // Request valid
    input  wire logic [3:0]               delay_i,     // Wait states
    input  wire prbw_pkg::prbw_mem_resp_t resp_i,      // Result to give
    output prbw_pkg::prbw_mem_resp_t      mem_resp_o,  // Result
    output logic                          mem_ready_o, // Request taken
    output logic                          mem_done_o   // Write done
);
    logic [3:0] cnt_ff;
    logic       busy_ff;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_ff      <= 4'h0;
            busy_ff     <= 1'b0;
            mem_ready_o <= 1'b0;
            mem_done_o  <= 1'b0;
            mem_resp_o  <= '0;
        end else begin
            mem_ready_o <= 1'b0;
            mem_done_o  <= 1'b0;
            mem_resp_o  <= ~mem_resp_o; // Inverted every cycle outside done
            if ((busy_ff || mem_valid_i) && !mem_ready_o) begin
                cnt_ff <= cnt_ff + 4'h1;
                if (cnt_ff == delay_i) begin
                    cnt_ff      <= 4'h0;
                    busy_ff     <= !busy_ff;
                    mem_ready_o <= !busy_ff;
                    mem_done_o  <= busy_ff;
                    if (busy_ff) begin
                        mem_resp_o <= resp_i;
                    end
                end
            end
        end
    end
endmodule

// ---- test/test_prbw_writer.sv ----
`timescale 1ns/1ns
module test_prbw_writer;
    import prbw_pkg::*;
    typedef struct packed {
        prbw_ctrl_t   c;
        logic [1:0]   el;
        logic         e_sec;
        logic [1:0]   e_el;
        logic         e_en;
        prbw_access_t e_acc;
    } prbw_row_t;
    logic           clk_i, reset_n_i = 1'b0, cur_a32_i = 1'b0, owner_a32_i = 1'b0;
    logic           ptr_we_i = 1'b0, stat_we_i = 1'b0, rec_valid_i = 1'b0, tlbi_sync_i = 1'b0;
    logic           rec_first_i = 1'b0, rec_last_i = 1'b0, mem_ready_i, mem_done_i;
    logic           rec_ready_o, mem_valid_o, tlbi_sync_done_o, buffer_enable_o;
    logic           prof_allowed_o, owner_secure_o;
    logic [1:0]     cur_el_i = 2'h0, owner_el_o;
    logic [3:0]     delay = 4'h0;
    logic [63:12]   limit_i = 52'h1;
    logic [63:0]    ptr_wdata_i = 64'h0, rec_data_i = 64'h0, ptr_o;
    prbw_ctrl_t     ctrl_i = '0;
    prbw_stat_t     stat_wdata_i = '0, stat_o;
    prbw_mem_req_t  mem_o;
    prbw_mem_resp_t mem_resp_i, resp = '0;
    prbw_access_t   access_o;
    int             failures = 0, n_compared = 0;
    // ****************************************
    // Owner, enable and access decode rows
    // ****************************************
    prbw_row_t rows [8] = '{
        '{9'h151, 2'h1, 1'h0, 2'h1, 1'h1, PRBW_ACC_TRAP_HV},
        '{9'h1f1, 2'h1, 1'h0, 2'h1, 1'h1, PRBW_ACC_OK},
        '{9'h111, 2'h2, 1'h0, 2'h2, 1'h1, PRBW_ACC_TRAP_MN},
        '{9'h001, 2'h1, 1'h1, 2'h1, 1'h1, PRBW_ACC_TRAP_MN},
        '{9'h081, 2'h1, 1'h1, 2'h1, 1'h1, PRBW_ACC_OK},
        '{9'h141, 2'h3, 1'h0, 2'h1, 1'h0, PRBW_ACC_OK},
        '{9'h1f0, 2'h0, 1'h0, 2'h1, 1'h0, PRBW_ACC_UNDEF},
        '{9'h051, 2'h1, 1'h1, 2'h1, 1'h0, PRBW_ACC_TRAP_HV}};

    prbw_writer i_prbw_writer (.clk_i, .reset_n_i, .ctrl_i, .cur_el_i, .cur_a32_i,
        .core_secure_i(!ctrl_i.nonsecure_state_bit), .owner_a32_i, .address_space_id_k_i(16'h0011),
        .address_space_id_h_i(16'h0022), .virtual_machine_id_i(16'h0033), .tbi_i(1'b1), .limit_i, .ptr_we_i,
        .ptr_wdata_i, .stat_we_i, .stat_wdata_i, .ptr_o, .stat_o, .rec_valid_i, .rec_data_i,
        .rec_first_i, .rec_last_i, .rec_ready_o, .mem_o, .mem_valid_o, .mem_ready_i,
        .mem_done_i, .mem_resp_i, .tlbi_sync_i, .tlbi_sync_done_o, .buffer_enable_o,
        .prof_allowed_o, .owner_secure_o, .owner_el_o, .access_o);
    prbw_mem_model i_prbw_mem_model (.clk_i, .reset_n_i, .mem_valid_i(mem_valid_o),
        .delay_i(delay), .resp_i(resp), .mem_resp_o(mem_resp_i), .mem_ready_o(mem_ready_i),
        .mem_done_o(mem_done_i));

    task automatic finish_test;
        if (failures == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        n_compared++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            failures++;
        end
    endtask

    task automatic wr(input logic pw, input logic sw, input logic [63:0] v);
        @(negedge clk_i);
        ptr_we_i     = pw;
        stat_we_i    = sw;
        ptr_wdata_i  = v;
        stat_wdata_i = v[14:0];
        @(negedge clk_i);
        ptr_we_i     = 1'b0;
        stat_we_i    = 1'b0;
    endtask

    // Holds the beat until an edge has seen ready, then waits for idle
    task automatic rec(input int n);
        int k;
        for (int b = 0; b < n; b++) begin
            @(negedge clk_i);
            rec_valid_i = 1'b1;
            rec_first_i = (b == 0);
            rec_last_i  = (b == n - 1);
            rec_data_i  = rec_data_i + 64'h1;
            for (k = 0; rec_ready_o !== 1'b1 && k < 50; k++) @(negedge clk_i);
            @(negedge clk_i);
            rec_valid_i = 1'b0;
            for (k = 0; rec_ready_o !== 1'b1 && k < 50; k++) @(negedge clk_i);
            chk("rec_ready", 64'h1, 64'(rec_ready_o));
            @(negedge clk_i);
        end
    endtask

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    initial begin
        #200000;
        $display("[ERR] watchdog expected finish seen timeout");
        failures++;
        finish_test();
    end

    initial begin
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        reset_n_i = 1'b1;
        foreach (rows[i]) begin
            @(negedge clk_i);
            ctrl_i   = rows[i].c;
            cur_el_i = rows[i].el;
            #1;
            chk("owner_sec", 64'(rows[i].e_sec), 64'(owner_secure_o));
            chk("owner_el", 64'(rows[i].e_el), 64'(owner_el_o));
            chk("buf_en", 64'(rows[i].e_en), 64'(buffer_enable_o));
            chk("access", 64'(rows[i].e_acc), 64'(access_o));
        end
        ctrl_i   = 9'h1f3;
        cur_el_i = EL_KERNEL;
        wr(1'b1, 1'b0, 64'hf80);
        rec(4);
        chk("ptr_a", 64'hfa0, ptr_o);
        chk("va_k", 64'hf98, mem_o.va);
        chk("address_space_id_k", 64'h11, 64'(mem_o.address_space_id));
        chk("virtual_machine_id_k", 64'h33, 64'(mem_o.virtual_machine_id));
        chk("s2_k", 64'h1, 64'(mem_o.stage2));
        delay = 4'h3;
        rec(4);
        chk("stat_a", 64'h0, 64'(stat_o));
        rec(4);
        chk("ptr_full", 64'hfe0, ptr_o);
        chk("stat_full", 64'h4001, 64'(stat_o));
        chk("en_svc", 64'h0, 64'(buffer_enable_o));
        rec(2);
        chk("ptr_svc", 64'hfe0, ptr_o);
        limit_i = 52'h2;
        wr(1'b0, 1'b1, 64'h0);
        rec(4);
        chk("ptr_ext", 64'h1000, ptr_o);
        resp = '{1'b1, 1'b0, 1'b1, 6'h05};
        rec(2);
        chk("stat_flt", 64'h4945, 64'(stat_o));
        chk("ptr_flt", 64'h1000, ptr_o);
        wr(1'b0, 1'b1, 64'h0);
        rec(1);
        chk("stat_reflt", 64'h4945, 64'(stat_o));
        resp = '0;
        wr(1'b0, 1'b1, 64'h0);
        wr(1'b1, 1'b0, 64'h1ff8);
        rec(2);
        chk("ptr_ovf", 64'h1ff8, ptr_o);
        chk("stat_ovf", 64'h6001, 64'(stat_o));
        wr(1'b0, 1'b1, 64'h0);
        tlbi_sync_i = 1'b1;
        owner_a32_i = 1'b1;
        cur_a32_i   = 1'b1;
        #1;
        chk("rdy_sync", 64'h0, 64'(rec_ready_o));
        chk("sync_done", 64'h1, 64'(tlbi_sync_done_o));
        chk("en_a32", 64'h0, 64'(buffer_enable_o));
        chk("acc_a32", 64'(PRBW_ACC_UNDEF), 64'(access_o));
        tlbi_sync_i = 1'b0;
        owner_a32_i = 1'b0;
        cur_a32_i   = 1'b0;
        cur_el_i    = EL_HYP;
        #1;
        chk("prof_hyp", 64'h0, 64'(prof_allowed_o));
        ctrl_i   = 9'h1fb;
        cur_el_i = EL_USER;
        #1;
        chk("prof_host", 64'h0, 64'(prof_allowed_o));
        cur_el_i = EL_KERNEL;
        #1;
        chk("prof_tge", 64'h0, 64'(prof_allowed_o));
        ctrl_i   = 9'h1f3;
        #1;
        chk("prof_k", 64'h1, 64'(prof_allowed_o));
        ctrl_i   = 9'h11d;
        cur_el_i = EL_HYP;
        wr(1'b1, 1'b0, 64'h1000);
        rec(1);
        chk("ptr_host", 64'h1008, ptr_o);
        chk("rg_host", 64'(PRBW_RG_HOST), 64'(mem_o.regime));
        chk("address_space_id_host", 64'h22, 64'(mem_o.address_space_id));
        finish_test();
    end
endmodule
